// [core/clock_control_regs.v]
// Purpose: clock-control register group and alignment capture control
// Assumes: simple byte register port, one access per cycle
// Notes:   position status updates on each accepted alignment edge
`include "clk_ctrl_map.vh"
`default_nettype none
module clock_control_regs #(
    parameter POS_WIDTH = 24
) (
    input  wire       clk,
    input  wire       rst_n,
    input  wire [7:0] reg_addr,
    input  wire       reg_wr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata_ff,
    input  wire       sysref_in,
    output reg        sysref_receiver_enable,
    output reg        sysref_processor_enable,
    output reg        window_fine_step,
    output reg  [3:0] capture_delay_select,
    output reg        alignment_input_invert,
    output reg        sample_clock_pecl_mode,
    output reg        alignment_input_pecl_mode,
    output reg        analog_supply_noise_suppress,
    output reg        clock_supply_noise_suppress,
    output reg        sysref_capture_strobe
);

    reg  [7:0]           window_ctrl_ff;
    reg  [7:0]           input_mode_ff;
    reg  [7:0]           supply_noise_ff;
    wire [POS_WIDTH-1:0] capture_position_status;
    wire                 capture_event;
    wire                 sysref_active;
    reg  [7:0]           nxt_rdata;
    wire [2:0]           slot;
    wire [7:0]           wdata_masked;
    wire                 wr_window;
    wire                 wr_mode;
    wire                 wr_supply;

    // Register slots; one decode serves the write and read paths
    localparam [2:0] SLOT_NONE   = 3'h0;
    localparam [2:0] SLOT_WINDOW = 3'h1;
    localparam [2:0] SLOT_MODE   = 3'h2;
    localparam [2:0] SLOT_SUPPLY = 3'h3;
    localparam [2:0] SLOT_POS_B0 = 3'h4;
    localparam [2:0] SLOT_POS_B1 = 3'h5;
    localparam [2:0] SLOT_POS_B2 = 3'h6;

    ////////////////////////////////////////////////////////////////////
    // Address decode

    // Maps a byte address onto its register slot
    function [2:0] addr_slot;
        input [7:0] addr;
        begin
            if (addr == `OFS_WINDOW_CTRL)
                addr_slot = SLOT_WINDOW;
            else if (addr == `OFS_INPUT_MODE)
                addr_slot = SLOT_MODE;
            else if (addr == `OFS_SUPPLY_NOISE)
                addr_slot = SLOT_SUPPLY;
            else if (addr == `OFS_POS_B0)
                addr_slot = SLOT_POS_B0;
            else if (addr == `OFS_POS_B1)
                addr_slot = SLOT_POS_B1;
            else if (addr == `OFS_POS_B2)
                addr_slot = SLOT_POS_B2;
            else
                addr_slot = SLOT_NONE;
        end
    endfunction

    // Writable bits of each slot; status and unmapped slots take none
    function [7:0] write_mask;
        input [2:0] s;
        begin
            if (s == SLOT_WINDOW)
                write_mask = `MASK_WINDOW_CTRL;
            else if (s == SLOT_MODE)
                write_mask = `MASK_INPUT_MODE;
            else if (s == SLOT_SUPPLY)
                write_mask = `MASK_SUPPLY_NOISE;
            else
                write_mask = 8'h00;
        end
    endfunction

    // Byte n of the capture position; bits past its width read as 0
    function [7:0] pos_byte;
        input [POS_WIDTH-1:0] pos;
        input [1:0]           n;
        integer               k;
        begin
            pos_byte = 8'h00;
            for (k = 0; k < 8; k = k + 1)
            begin
                if (8 * n + k < POS_WIDTH)
                    pos_byte[k] = pos[8 * n + k];
            end
        end
    endfunction

    assign slot         = addr_slot(reg_addr);
    assign wdata_masked = reg_wdata & write_mask(slot);
    assign wr_window    = reg_wr && (slot == SLOT_WINDOW);
    assign wr_mode      = reg_wr && (slot == SLOT_MODE);
    assign wr_supply    = reg_wr && (slot == SLOT_SUPPLY);

    ////////////////////////////////////////////////////////////////////
    // Register writes
    // Window bit 7 is stored as written; keeping it set is the host's job

    always @(posedge clk)
    begin
        if (!rst_n)
            window_ctrl_ff <= `RST_WINDOW_CTRL; // RQ2 RQ4 RQ7
        else if (wr_window)
            window_ctrl_ff <= wdata_masked;
    end

    always @(posedge clk)
    begin
        if (!rst_n)
            input_mode_ff <= `RST_INPUT_MODE;
        else if (wr_mode)
            input_mode_ff <= wdata_masked;
    end

    always @(posedge clk)
    begin
        if (!rst_n)
            supply_noise_ff <= `RST_SUPPLY_NOISE;
        else if (wr_supply)
            supply_noise_ff <= wdata_masked;
    end

    ////////////////////////////////////////////////////////////////////
    // Field outputs

    // Window control fields
    always @*
    begin
        sysref_processor_enable  = window_ctrl_ff[`BIT_WC_PROC_EN]; // RQ2
        sysref_receiver_enable   = window_ctrl_ff[`BIT_WC_RECV_EN]; // RQ4
        window_fine_step         = window_ctrl_ff[`BIT_WC_FINE_STEP]; // RQ5
        capture_delay_select     =
            window_ctrl_ff[`FLD_WC_SEL_HI:`FLD_WC_SEL_LO]; // RQ7
    end

    // Input mode fields
    always @*
    begin
        alignment_input_invert   = input_mode_ff[`BIT_IM_INVERT]; // RQ9
        sample_clock_pecl_mode   = input_mode_ff[`BIT_IM_CLK_PECL]; // RQ10
        alignment_input_pecl_mode =
            input_mode_ff[`BIT_IM_ALIGN_PECL]; // RQ11
    end

    // Supply fields and capture strobe
    always @*
    begin
        analog_supply_noise_suppress = supply_noise_ff[`BIT_SN_ANALOG];
        clock_supply_noise_suppress  = supply_noise_ff[`BIT_SN_CLOCK];
        sysref_capture_strobe        = capture_event;
    end

    // The processor needs a live receiver; either bit off blocks events
    assign sysref_active = sysref_receiver_enable &&
                           sysref_processor_enable; // RQ13 RQ3

    ////////////////////////////////////////////////////////////////////
    // Position detector

    sysref_position_detector #(
        .TAPS (POS_WIDTH)
    ) u_detector (
        .clk          (clk),
        .rst_n        (rst_n),
        .active       (sysref_active),
        .fine_step    (window_fine_step),
        .invert       (alignment_input_invert),
        .sysref_in    (sysref_in),
        .delay_select (capture_delay_select),
        .position_ff  (capture_position_status),
        .event_ff     (capture_event)
    );

    ////////////////////////////////////////////////////////////////////
    // Read path; status bytes ignore writes

    // Position bytes are live: an edge between byte reads shows up in
    // whichever bytes are read after it
    always @*
    begin
        nxt_rdata = 8'h00;
        if (slot == SLOT_WINDOW)
            nxt_rdata = window_ctrl_ff;
        else if (slot == SLOT_MODE)
            nxt_rdata = input_mode_ff;
        else if (slot == SLOT_SUPPLY)
            nxt_rdata = supply_noise_ff;
        else if (slot == SLOT_POS_B0)
            nxt_rdata = pos_byte(capture_position_status, 2'h0); // RQ12
        else if (slot == SLOT_POS_B1)
            nxt_rdata = pos_byte(capture_position_status, 2'h1);
        else if (slot == SLOT_POS_B2)
            nxt_rdata = pos_byte(capture_position_status, 2'h2);
    end

    // Read data holds until the next read strobe

    always @(posedge clk)
    begin
        if (!rst_n)
            reg_rdata_ff <= 8'h00;
        else if (reg_rd)
            reg_rdata_ff <= nxt_rdata;
    end

endmodule
`default_nettype wire

// [core/clk_ctrl_map.vh]
// Purpose: offsets, fields, reset values for the clock-control registers
// Assumes: byte-addressed register space, 8-bit register lanes
// Notes:   the capture position status spans three byte addresses
// Behaviour
// RQ1: Host keeps window control bit 7 one
// RQ2: Bit 6 enables SYSREF processor, resets zero
// RQ3: Host enables receiver before processor
// RQ4: Bit 5 enables SYSREF receiver, resets off
// RQ5: Bit 4 selects fine window delay steps
// RQ6: Software enables fine steps at high rates
// RQ7: Bits 3:0 select capture delay tap
// RQ8: Software picks tap from position status
// RQ9: Mode bit 0 inverts alignment input
// RQ10: Mode bit 2 sets sample clock PECL
// RQ11: Mode bit 1 sets alignment input PECL
// RQ12: Read-only 24-bit capture position status
// RQ13: Events act only when both enables set
`ifndef CLK_CTRL_MAP_VH
`define CLK_CTRL_MAP_VH

`define OFS_WINDOW_CTRL     8'h29
`define OFS_INPUT_MODE      8'h2a
`define OFS_SUPPLY_NOISE    8'h2b
`define OFS_POS_B0          8'h2c
`define OFS_POS_B1          8'h2d
`define OFS_POS_B2          8'h2e

`define RST_WINDOW_CTRL     8'h80
`define RST_INPUT_MODE      8'h00
`define RST_SUPPLY_NOISE    8'h10
`define RST_POS             24'h000000

`define BIT_WC_RESERVED     7
`define BIT_WC_PROC_EN      6
`define BIT_WC_RECV_EN      5
`define BIT_WC_FINE_STEP    4
`define FLD_WC_SEL_HI       3
`define FLD_WC_SEL_LO       0

`define BIT_IM_CLK_PECL     2
`define BIT_IM_ALIGN_PECL   1
`define BIT_IM_INVERT       0

`define BIT_SN_ANALOG       2
`define BIT_SN_CLOCK        0

`define MASK_WINDOW_CTRL    8'hff
`define MASK_INPUT_MODE     8'h07
`define MASK_SUPPLY_NOISE   8'hff

`endif

// [core/sysref_position_detector.v]
// Purpose: samples the alignment input on a ladder of delay taps
// Assumes: alignment input synchronous to clk; one tap per cycle delay
// Notes:   fine step halves tap spacing; events fire on the selected tap
`default_nettype none
module sysref_position_detector #(
    parameter TAPS = 24
) (
    input  wire            clk,
    input  wire            rst_n,
    input  wire            active,
    input  wire            fine_step,
    input  wire            invert,
    input  wire            sysref_in,
    input  wire [3:0]      delay_select,
    output reg  [TAPS-1:0] position_ff,
    output reg             event_ff
);

    reg  [2*TAPS-1:0] line_ff;
    reg               prev_ff;
    reg  [TAPS-1:0]   snap;
    wire              aligned;
    wire [4:0]        tap_index;
    wire              tap;
    integer           i;

    assign aligned = sysref_in ^ invert; // RQ9

    // Fine spacing walks the taps one apart, coarse two apart
    assign tap_index = fine_step ? {1'b0, delay_select}
                                 : {delay_select, 1'b0}; // RQ5 RQ7
    assign tap       = line_ff[tap_index];

    always @*
    begin
        snap = {TAPS{1'b0}};
        for (i = 0; i < TAPS; i = i + 1)
        begin
            if (fine_step) // RQ5
                snap[i] = line_ff[i];
            else
                snap[i] = line_ff[2*i];
        end
    end

    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            line_ff     <= {2*TAPS{1'b0}};
            prev_ff     <= 1'b0;
            position_ff <= {TAPS{1'b0}};
            event_ff    <= 1'b0;
        end
        else
        begin
            line_ff  <= {line_ff[2*TAPS-2:0], aligned};
            prev_ff  <= tap;
            event_ff <= 1'b0;
            if (active && tap && !prev_ff) // RQ13
            begin
                position_ff <= snap; // RQ12
                event_ff    <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// [verification/clock_control_regs_assertions.sv]
// Purpose: port assertions for the clock control registers
// Assumes: fields follow a register write one cycle later
// Notes:   bound to every instance of the register block
`default_nettype none
module clock_control_regs_assertions (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic       sysref_receiver_enable,
    input wire logic       sysref_processor_enable,
    input wire logic [3:0] capture_delay_select,
    input wire logic       alignment_input_invert,
    input wire logic       sample_clock_pecl_mode,
    input wire logic       alignment_input_pecl_mode,
    input wire logic       sysref_capture_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence wc_wr;
        reg_wr && reg_addr == 8'h29;
    endsequence
    sequence im_wr;
        reg_wr && reg_addr == 8'h2a;
    endsequence
    proc_en_a: assert property (wc_wr |=>
        sysref_processor_enable == $past(reg_wdata[6])) else $error("proc");
    proc_hold_a: assert property (!reg_wr |=>
        $stable(sysref_processor_enable)) else $error("proc hold");
    recv_en_a: assert property (wc_wr |=>
        sysref_receiver_enable == $past(reg_wdata[5])) else $error("recv");
    delay_sel_a: assert property (wc_wr |=>
        capture_delay_select == $past(reg_wdata[3:0])) else $error("sel");
    invert_a: assert property (im_wr |=>
        alignment_input_invert == $past(reg_wdata[0])) else $error("inv");
    clk_pecl_a: assert property (im_wr |=>
        sample_clock_pecl_mode == $past(reg_wdata[2])) else $error("ckpecl");
    align_pecl_a: assert property (im_wr |=>
        alignment_input_pecl_mode == $past(reg_wdata[1]))
        else $error("alpecl");
    event_gate_a: assert property (sysref_capture_strobe |->
        $past(sysref_receiver_enable && sysref_processor_enable))
        else $error("gate");
endmodule
bind clock_control_regs clock_control_regs_assertions chk (.*);
`default_nettype wire

// [verification/align_source.sv]
// Purpose: alignment pulse source facing the register block
// Assumes: one clock domain
// Notes:   each fire gives a six cycle pulse, idle low
`default_nettype none
module align_source (
    input  wire logic clk,
    input  wire logic fire,
    output wire logic sysref_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] left_ff = 3'h0;
    always @(posedge clk)
        left_ff <= fire ? 3'h6 : left_ff - {2'h0, left_ff != 3'h0};
    assign sysref_out = left_ff != 3'h0;
endmodule
`default_nettype wire

// [verification/clock_control_regs_tb.sv]
// Purpose: register and capture bench for the clock control block
// Assumes: inputs driven on the falling edge
// Notes:   host keeps window bit 7 set in every write
`default_nettype none
module clock_control_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic       reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_rd = 1'b0;
    logic       fire = 1'b0;
    logic [7:0] n_strobe = 8'h00;
    int         n_mismatch = 0;
    int         n_checks = 0;
    wire logic [7:0] reg_rdata_ff;
    wire logic [3:0] capture_delay_select;
    wire logic sysref_in, sysref_receiver_enable, sysref_processor_enable;
    wire logic window_fine_step, alignment_input_invert;
    wire logic sample_clock_pecl_mode, alignment_input_pecl_mode;
    wire logic sysref_capture_strobe;
    wire logic analog_supply_noise_suppress, clock_supply_noise_suppress;
    clock_control_regs dut (
        .clk                          (clk),
        .rst_n                        (rst_n),
        .reg_addr                     (reg_addr),
        .reg_wr                       (reg_wr),
        .reg_wdata                    (reg_wdata),
        .reg_rd                       (reg_rd),
        .reg_rdata_ff                 (reg_rdata_ff),
        .sysref_in                    (sysref_in),
        .sysref_receiver_enable       (sysref_receiver_enable),
        .sysref_processor_enable      (sysref_processor_enable),
        .window_fine_step             (window_fine_step),
        .capture_delay_select         (capture_delay_select),
        .alignment_input_invert       (alignment_input_invert),
        .sample_clock_pecl_mode       (sample_clock_pecl_mode),
        .alignment_input_pecl_mode    (alignment_input_pecl_mode),
        .analog_supply_noise_suppress (analog_supply_noise_suppress),
        .clock_supply_noise_suppress  (clock_supply_noise_suppress),
        .sysref_capture_strobe        (sysref_capture_strobe)
    );
    align_source src (.clk(clk), .fire(fire), .sysref_out(sysref_in));
    always #4 clk = ~clk;
    always @(posedge clk)
        if (sysref_capture_strobe === 1'b1)
            n_strobe <= n_strobe + 8'h01;
    task automatic chk(input logic [7:0] e, s, input string n);
        n_checks++;
        if (s !== e)
        begin
            $display("Error %s expected %h seen %h", n, e, s);
            n_mismatch++;
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, e);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        chk(e, reg_rdata_ff, "rdata");
    endtask
    task automatic pulse;
        @(negedge clk);
        fire = 1'b1;
        @(negedge clk);
        fire = 1'b0;
        repeat (12) @(negedge clk);
    endtask
    task automatic stop_test;
        $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        rd(8'h29, 8'h80);
        rd(8'h2a, 8'h00);
        rd(8'h2b, 8'h10);
        wr(8'h2c, 8'hff);
        rd(8'h2c, 8'h00);
        rd(8'h40, 8'h00);
        wr(8'h2b, 8'h15);
        rd(8'h2b, 8'h15);
        chk(8'h05, {5'h00, analog_supply_noise_suppress, 1'b0,
            clock_supply_noise_suppress}, "supply");
        wr(8'h2a, 8'hff);
        rd(8'h2a, 8'h07);
        wr(8'h2a, 8'h04);
        wr(8'h29, 8'ha0);
        pulse;
        chk(8'h00, n_strobe, "strobes");
        wr(8'h29, 8'hf3);
        rd(8'h29, 8'hf3);
        chk(8'h01, {7'h00, window_fine_step}, "fine_step");
        pulse;
        chk(8'h01, n_strobe, "strobes");
        rd(8'h2c, 8'h0f);
        wr(8'h29, 8'he1);
        pulse;
        chk(8'h02, n_strobe, "strobes");
        rd(8'h2c, 8'h03);
        stop_test;
    end
endmodule
`default_nettype wire
